// *** include/see_pkg.sv ***
// Constants shared by the two-wire serial memory slave.
package see_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned WRITE_MS        = 5;
  localparam int unsigned WRITE_CYCLES    = WRITE_MS * (CLK_HZ / 1000);
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned MEM_DEPTH       = 256;
  localparam int unsigned PAGE_BITS       = 3;
  localparam int unsigned PAGE_BYTES      = 8;
  localparam logic [7:0]  ADDR_RESET      = 8'h00;
  localparam logic [3:0]  BIT_CNT_ACK     = 4'h8;
  localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
  localparam int unsigned CTRL_CODE_MSB   = 7;
  localparam int unsigned CTRL_CODE_LSB   = 4;
  localparam int unsigned CTRL_RW_BIT     = 0;
  localparam logic [3:0]  DEV_CODE_DEFAULT = 4'h5;

  typedef enum logic [2:0] {
    SEE_IDLE  = 3'b000,
    SEE_CTRL  = 3'b001,
    SEE_ADDR  = 3'b010,
    SEE_WDATA = 3'b011,
    SEE_RDATA = 3'b100,
    SEE_RACK  = 3'b101,
    SEE_SKIP  = 3'b110
  } see_state_t;
endpackage

// *** hw/see_slave.sv ***
// Two-wire slave front end of a 256-byte serial memory with page buffer.
`timescale 1ns/1ns

// Overview of operation
// - Matching write control byte is acknowledged on the ninth clock.
// - Next byte loads the word address pointer and is acknowledged.
// - Stop after data starts self-timed write; no acknowledges while busy.
// - Up to eight data bytes held in page buffer, committed at Stop.
// - Each data byte increments only the low pointer bits; upper bits fixed.
// - More than eight bytes roll the in-page counter and overwrite buffer.
// - Page writes wrap to the start of the same aligned page.
// - Polling: busy device withholds acknowledge, acknowledges once write ends.
// - Write-protect high inhibits all array writes; reads unaffected.
// - Current-address read sends byte at one past the last access.
// - Master not-acknowledge then Stop ends a read; device stops driving.
// - Repeated Start after address keeps pointer, discards write, then reads.
// - Master acknowledge during read makes device send the next byte.
// - Pointer increments after every access, allowing full-array readout.
// - Data changes while clock high are Start or Stop conditions.
// - Low-supply indication disables internal write logic.
// - Acknowledge control only on type code match; three bits ignored.
// - Start is data falling with clock high; Stop is data rising.
// - After read not-acknowledge the device releases the data line high.
// - Self-timed write completes within five milliseconds.
module see_slave #(
  parameter int unsigned WRITE_CYCLES = see_pkg::WRITE_CYCLES, // Write cycle length.
  parameter logic [3:0]  DEV_CODE     = see_pkg::DEV_CODE_DEFAULT // Arbitrary type code.
) (
  input  wire logic clk,                 // System clock, 25 MHz.
  input  wire logic rst_b,               // Asynchronous reset, active low.
  input  wire logic scl_i,               // Serial clock pin.
  input  wire logic sda_i,               // Serial data pin level.
  output logic      sda_o,               // Serial data drive value, always low.
  output logic      sda_oe,              // High while pulling the data line low.
  input  wire logic wp_i,                // Write-protect pin, high protects.
  input  wire logic supply_low_i,        // Supply below the write threshold.
  input  wire logic unused_select_pin_0, // Not used.
  input  wire logic unused_select_pin_1, // Not used.
  input  wire logic unused_select_pin_2, // Not used.
  output logic      busy_o               // Self-timed write in progress.
);

  typedef struct packed {
    logic [1:0]         scl_sync;
    logic [1:0]         sda_sync;
    logic               scl_prev;
    logic               sda_prev;
    logic [1:0]         wp_sync;
    logic [1:0]         low_sync;
    see_pkg::see_state_t state;
    logic [3:0]         bit_cnt;
    logic [7:0]         shift;
    logic               ack;
    logic               tx;
    logic [7:0]         ptr;
    logic [7:0]         page_base;
    logic [7:0]         buf_mask;
    logic [63:0]        buf_data;
    logic               wr_pend;
    logic               busy;
    logic [22:0]        wc_cnt;
    logic               commit;
  } see_reg_t;

  see_reg_t q, d;
  logic [7:0] mem_q [see_pkg::MEM_DEPTH];
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

  // Pointer increment limited to the in-page bits.
  function automatic logic [7:0] page_inc(input logic [7:0] a);
    page_inc = {a[7:see_pkg::PAGE_BITS], a[see_pkg::PAGE_BITS-1:0] + 3'h1};
  endfunction

  assign scl      = q.scl_sync[1];
  assign sda      = q.sda_sync[1];
  assign scl_rise = scl & ~q.scl_prev;
  assign scl_fall = ~scl & q.scl_prev;
  assign start_c  = scl & q.scl_prev & q.sda_prev & ~sda;
  assign stop_c   = scl & q.scl_prev & ~q.sda_prev & sda;

  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[0], scl_i};
    d.sda_sync = {q.sda_sync[0], sda_i};
    // The straps are pins too, so they pass the same two flops as the bus lines.
    d.wp_sync  = {q.wp_sync[0], wp_i};
    d.low_sync = {q.low_sync[0], supply_low_i};
    d.scl_prev = scl;
    d.sda_prev = sda;
    d.commit   = 1'b0;
    if (q.busy) begin
      if (q.wc_cnt == 23'(WRITE_CYCLES - 1)) begin
        d.busy = 1'b0;
      end else begin
        d.wc_cnt = q.wc_cnt + 23'h1;
      end
    end
    if (stop_c) begin
      d.state = see_pkg::SEE_IDLE;
      d.ack   = 1'b0;
      d.tx    = 1'b0;
      // Protected or low-supply writes are dropped silently at Stop.
      if (q.wr_pend && q.state == see_pkg::SEE_WDATA
          && !q.wp_sync[1] && !q.low_sync[1]) begin
        d.commit = 1'b1;
        d.busy   = 1'b1;
        d.wc_cnt = 23'h0;
      end
      d.wr_pend = 1'b0;
    end else if (start_c) begin
      // A repeated Start discards buffered data but keeps the pointer.
      d.state   = see_pkg::SEE_CTRL;
      // The SCL fall that follows Start closes no bit, so the counter waits in
      // the acknowledge slot and that fall only rewinds it to zero.
      d.bit_cnt = see_pkg::BIT_CNT_ACK;
      d.ack     = 1'b0;
      d.tx      = 1'b0;
      d.wr_pend = 1'b0;
      d.buf_mask = 8'h00;
    end else if (q.state != see_pkg::SEE_IDLE && q.state != see_pkg::SEE_SKIP) begin
      if (scl_rise && q.bit_cnt != see_pkg::BIT_CNT_ACK) begin
        d.shift = {q.shift[6:0], sda};
      end
      if (scl_rise && q.bit_cnt == see_pkg::BIT_CNT_ACK && q.state == see_pkg::SEE_RACK) begin
        if (sda) begin
          d.state = see_pkg::SEE_SKIP;
        end
      end
      if (scl_fall) begin
        if (q.bit_cnt == see_pkg::BIT_CNT_ACK) begin
          d.bit_cnt = see_pkg::BIT_CNT_RESET;
          d.ack     = 1'b0;
          if (q.state == see_pkg::SEE_RDATA || q.state == see_pkg::SEE_RACK) begin
            d.state = see_pkg::SEE_RDATA;
            d.shift = mem_q[q.ptr];
            d.ptr   = q.ptr + 8'h01;
            d.tx    = ~mem_q[q.ptr][7];
          end
        end else if (q.bit_cnt == 4'h7) begin
          d.bit_cnt = see_pkg::BIT_CNT_ACK;
          d.tx      = 1'b0;
          case (q.state)
            see_pkg::SEE_CTRL: begin
              if (q.shift[see_pkg::CTRL_CODE_MSB:see_pkg::CTRL_CODE_LSB] == DEV_CODE
                  && !q.busy) begin
                d.ack = 1'b1;
                d.state = q.shift[see_pkg::CTRL_RW_BIT] ? see_pkg::SEE_RDATA
                                                        : see_pkg::SEE_ADDR;
              end else begin
                d.state = see_pkg::SEE_SKIP;
              end
            end
            see_pkg::SEE_ADDR: begin
              d.ptr       = q.shift;
              d.page_base = q.shift;
              d.buf_mask  = 8'h00;
              d.ack       = 1'b1;
              d.state     = see_pkg::SEE_WDATA;
            end
            see_pkg::SEE_WDATA: begin
              d.buf_data[q.ptr[2:0]*8 +: 8] = q.shift;
              d.buf_mask[q.ptr[2:0]]        = 1'b1;
              d.ptr     = page_inc(q.ptr);
              d.wr_pend = 1'b1;
              d.ack     = 1'b1;
            end
            see_pkg::SEE_RDATA: begin
              d.state = see_pkg::SEE_RACK;
            end
            default: begin
              d.state = see_pkg::SEE_SKIP;
            end
          endcase
        end else begin
          d.bit_cnt = q.bit_cnt + 4'h1;
          if (q.state == see_pkg::SEE_RDATA) begin
            // Rising edges keep shifting, so the next bit always sits at the top.
            d.tx = ~q.shift[7];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.scl_sync <= 2'b11;
      q.sda_sync <= 2'b11;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.ptr      <= see_pkg::ADDR_RESET;
    end else begin
      q <= d;
    end
  end

  // The array has no reset; its contents model nonvolatile cells.
  always_ff @(posedge clk) begin
    if (q.commit) begin
      for (int i = 0; i < see_pkg::PAGE_BYTES; i++) begin
        if (q.buf_mask[i]) begin
          mem_q[{q.page_base[7:3], 3'(i)}] <= q.buf_data[i*8 +: 8];
        end
      end
    end
  end

  // The data pin is driven only low; a one bit or idle is a released line.
  assign sda_o  = 1'b0;
  assign sda_oe = q.ack | q.tx;
  assign busy_o = q.busy;

  // All checks sample the registered state, so each one sees a single
  // consistent snapshot of the bit engine per system clock.

  // Control byte: the type code and busy decide, the select bits never do.
  a_busy_no_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (q.busy && q.state == see_pkg::SEE_CTRL && scl_fall && q.bit_cnt == 4'h7)
    |=> !q.ack)
    else $error("ack given while write busy");

  a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (q.busy && q.state == see_pkg::SEE_CTRL && scl_fall && q.bit_cnt == 4'h7)
    |=> q.state == see_pkg::SEE_SKIP)
    else $error("busy device did not ignore the transfer");

  a_ctrl_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_CTRL && scl_fall && q.bit_cnt == 4'h7 && !q.busy
     && q.shift[see_pkg::CTRL_CODE_MSB:see_pkg::CTRL_CODE_LSB] == DEV_CODE)
    |=> q.ack && q.bit_cnt == see_pkg::BIT_CNT_ACK)
    else $error("matching control byte not acknowledged");

  a_code_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_CTRL && scl_fall && q.bit_cnt == 4'h7
     && q.shift[see_pkg::CTRL_CODE_MSB:see_pkg::CTRL_CODE_LSB] != DEV_CODE)
    |=> !q.ack && q.state == see_pkg::SEE_SKIP)
    else $error("foreign control byte acknowledged");

  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_CTRL && scl_fall && q.bit_cnt == 4'h7 && !q.busy
     && q.shift[see_pkg::CTRL_CODE_MSB:see_pkg::CTRL_CODE_LSB] == DEV_CODE
     && q.shift[see_pkg::CTRL_RW_BIT])
    |=> q.state == see_pkg::SEE_RDATA)
    else $error("read control byte did not select a read");

  a_start_ctrl: assert property (@(posedge clk) disable iff (!rst_b)
    start_c |=> q.state == see_pkg::SEE_CTRL && !sda_oe)
    else $error("start not honoured");

  a_start_drop: assert property (@(posedge clk) disable iff (!rst_b)
    start_c |=> !q.wr_pend && q.buf_mask == 8'h00 && q.ptr == $past(q.ptr))
    else $error("repeated start kept data or lost the pointer");

  a_stop_idle: assert property (@(posedge clk) disable iff (!rst_b)
    stop_c |=> q.state == see_pkg::SEE_IDLE && !sda_oe)
    else $error("stop not honoured");

  // Write cycle: started only by Stop after data, never while protected.
  a_commit_busy: assert property (@(posedge clk) disable iff (!rst_b)
    q.commit |-> q.busy && q.wc_cnt == 23'h0)
    else $error("commit without busy");

  a_stop_commit: assert property (@(posedge clk) disable iff (!rst_b)
    (stop_c && q.state == see_pkg::SEE_WDATA && q.wr_pend && !q.wp_sync[1] && !q.low_sync[1])
    |=> q.commit && q.busy)
    else $error("stop after data started no write cycle");

  a_bare_stop: assert property (@(posedge clk) disable iff (!rst_b)
    (stop_c && !q.wr_pend) |=> !q.commit)
    else $error("write cycle started without data");

  a_wp_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    (stop_c && q.wp_sync[1]) |=> !q.commit)
    else $error("write while protected");

  a_low_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    (stop_c && q.low_sync[1]) |=> !q.commit)
    else $error("write while supply low");

  a_busy_len: assert property (@(posedge clk) disable iff (!rst_b)
    (q.busy && q.wc_cnt != 23'(WRITE_CYCLES - 1)) |=> q.busy)
    else $error("write cycle ended early");

  a_busy_end: assert property (@(posedge clk) disable iff (!rst_b)
    (q.busy && q.wc_cnt == 23'(WRITE_CYCLES - 1)) |=> !q.busy)
    else $error("write cycle did not end");

  a_busy_bound: assert property (@(posedge clk) disable iff (!rst_b)
    q.wc_cnt <= 23'(WRITE_CYCLES - 1))
    else $error("write cycle overran");

  a_addr_load: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_ADDR && scl_fall && q.bit_cnt == 4'h7 && !stop_c && !start_c)
    |=> q.ptr == $past(q.shift) && q.ack)
    else $error("address not loaded");

  a_wdata_ack: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_WDATA && scl_fall && q.bit_cnt == 4'h7)
    |=> q.ack && q.wr_pend && q.buf_mask[$past(q.ptr[2:0])])
    else $error("data byte not buffered");

  a_page_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_WDATA && scl_fall && q.bit_cnt == 4'h7 && !stop_c && !start_c)
    |=> q.ptr[7:3] == $past(q.ptr[7:3]) && q.ptr[2:0] == $past(q.ptr[2:0]) + 3'h1)
    else $error("page pointer step wrong");

  a_page_keep: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_WDATA && scl_fall && q.bit_cnt == 4'h7)
    |=> q.ptr[7:3] == q.page_base[7:3])
    else $error("pointer left its page");

  // Read path: the pointer moves as each byte is loaded for sending.
  a_rd_next: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_RACK && scl_fall && q.bit_cnt == see_pkg::BIT_CNT_ACK)
    |=> q.state == see_pkg::SEE_RDATA && q.ptr == $past(q.ptr) + 8'h01)
    else $error("next read byte not started");

  a_rd_first: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_RDATA && scl_fall && q.bit_cnt == see_pkg::BIT_CNT_ACK)
    |=> q.ptr == $past(q.ptr) + 8'h01)
    else $error("first read byte did not advance the pointer");

  a_nack_release: assert property (@(posedge clk) disable iff (!rst_b)
    (q.state == see_pkg::SEE_RACK && scl_rise && sda && q.bit_cnt == see_pkg::BIT_CNT_ACK
     && !stop_c && !start_c) |=> q.state == see_pkg::SEE_SKIP ##1 !sda_oe)
    else $error("line not released after nack");

  a_skip_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    q.state == see_pkg::SEE_SKIP |-> !sda_oe)
    else $error("line driven while ignoring the bus");

  // A drive change with the clock high would look like Start or Stop to others.
  a_oe_scl_low: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(sda_oe) |-> !scl || $past(stop_c) || $past(start_c))
    else $error("data drive changed while clock high");

endmodule

// *** dv/see_master.sv ***
// Two-wire bus master model that drives the serial memory slave.
`timescale 1ns/1ns
module see_master (
  input  wire logic       clk,    // System clock that paces the bus.
  input  wire logic       sda_i,  // Resolved data line.
  output logic            scl_o,  // Serial clock, high when idle.
  output logic            sda_oe, // High while pulling data low.
  output logic [7:0]      res,    // Byte read or acknowledge level seen.
  output logic            res_ev  // Toggles when res is new.
);
  initial begin
    scl_o = 1'b1;
    sda_oe = 1'b0;
    res = 8'h00;
    res_ev = 1'b0;
  end
  task automatic step(input logic c, input logic d, input int n);
    sda_oe = d;
    scl_o = c;
    repeat (n) @(negedge clk);
  endtask
  // Data only moves with the clock low; these two move it high on purpose.
  task automatic start();
    step(1'b0, 1'b0, 2);
    step(1'b1, 1'b0, 2);
    step(1'b1, 1'b1, 2);
    step(1'b0, 1'b1, 2);
  endtask
  task automatic stop();
    step(1'b0, 1'b1, 2);
    step(1'b1, 1'b1, 2);
    step(1'b1, 1'b0, 4);
  endtask
  task automatic bit_io(input logic b, output logic s);
    step(1'b0, ~b, 2);
    step(1'b1, ~b, 4);
    s = sda_i;
    step(1'b0, ~b, 2);
  endtask
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    res = {7'h00, s};
    res_ev = ~res_ev;
  endtask
  task automatic recv(input logic ack);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~ack, s);
    res = v;
    res_ev = ~res_ev;
  endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the serial memory slave.
`timescale 1ns/1ns
module testbench;
  localparam logic [3:0] CODE = 4'h5; // Arbitrary type code.
  logic       clk, rst_b, wp, low, busy, m_scl, m_oe, d_oe, d_o, sda, res_ev;
  logic [2:0] sel;
  logic [7:0] res;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  int         bad_count, n_compared, cyc;
  // The pull-up holds the line high whenever nobody pulls it.
  assign sda = ~(m_oe | (d_oe & ~d_o));
  see_master i_mst (.clk(clk), .sda_i(sda), .scl_o(m_scl), .sda_oe(m_oe), .res(res),
    .res_ev(res_ev));
  see_slave #(.WRITE_CYCLES(200), .DEV_CODE(CODE)) i_dut (.clk(clk), .rst_b(rst_b),
    .scl_i(m_scl), .sda_i(sda), .sda_o(d_o), .sda_oe(d_oe), .wp_i(wp), .supply_low_i(low),
    .unused_select_pin_0(sel[0]), .unused_select_pin_1(sel[1]),
    .unused_select_pin_2(sel[2]), .busy_o(busy));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] ctl(input logic r);
    return {CODE, 3'($urandom), r};
  endfunction
  task automatic wr(input logic [7:0] d, input logic nak);
    exp_q.push_back({7'h00, nak});
    i_mst.send(d);
  endtask
  task automatic rd(input logic [7:0] e, input logic ack);
    exp_q.push_back(e);
    i_mst.recv(ack);
  endtask
  task automatic setp(input logic [7:0] a);
    i_mst.start();
    wr(ctl(1'b0), 1'b0);
    wr(a, 1'b0);
  endtask
  task automatic rdseq(input logic [7:0] a, input int n);
    setp(a);
    i_mst.start();
    wr(ctl(1'b1), 1'b0);
    for (int i = 0; i < n; i++) rd(mem[8'(a + i)], i < n - 1);
    i_mst.stop();
  endtask
  always @(res_ev) begin
    if (exp_q.size() > 0) chk("sda_result", exp_q.pop_front(), res);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    logic [7:0] d;
    void'($urandom(96873));
    rst_b = 1'b0;
    wp = 1'b0;
    low = 1'b0;
    sel = 3'($urandom);
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    i_mst.start();
    wr({~CODE, 4'h0}, 1'b1);
    i_mst.stop();
    // Nine bytes from 0x0B run past the page end and wrap onto the first slot.
    setp(8'h0B);
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      mem[{5'h01, 3'(3 + i)}] = d;
      wr(d, 1'b0);
    end
    i_mst.stop();
    i_mst.start();
    wr(ctl(1'b0), 1'b1);
    i_mst.stop();
    chk("busy_o", 8'h01, {7'h00, busy});
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
    chk("busy_o", 8'h00, {7'h00, busy});
    i_mst.start();
    wr(ctl(1'b0), 1'b0);
    i_mst.stop();
    rdseq(8'h09, 6);
    i_mst.start();
    wr(ctl(1'b1), 1'b0);
    rd(mem[8'h0F], 1'b0);
    i_mst.stop();
    for (int k = 0; k < 2; k++) begin
      wp = (k == 0);
      low = (k == 1);
      setp(8'h0C);
      wr(~mem[8'h0C], 1'b0);
      i_mst.stop();
      repeat (8) @(negedge clk);
      chk("busy_o", 8'h00, {7'h00, busy});
      rdseq(8'h0C, 1);
    end
    wp = 1'b0;
    low = 1'b0;
    chk("exp_q_left", 8'h00, 8'(exp_q.size()));
    report_and_stop();
  end
endmodule
